// ### pkg/acs_pkg.sv
package acs_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CLKDIV = 8'h04;
   localparam logic [7:0] ADDR_RESULT = 8'h08;
   localparam logic [7:0] ADDR_PREV = 8'h0c;
   localparam logic [7:0] ADDR_ACC = 8'h10;
   localparam logic [7:0] ADDR_ACQ = 8'h14;
   localparam logic [7:0] ADDR_PRE = 8'h18;
   localparam logic [7:0] ADDR_THRESH = 8'h1c;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_TRIG = 8'h24;
   // Control register fields
   localparam int CTRL_START = 0;
   localparam int CTRL_FORMAT = 2;
   localparam int CTRL_CLKSEL = 4;
   localparam int CTRL_CONTINUOUS_BIT = 6;
   localparam int CTRL_ON = 7;
   localparam int CTRL_DSEN = 8;
   localparam int CTRL_PSIS = 9;
   localparam int CTRL_IRQEN = 10;
   // Status register fields
   localparam int STAT_DONE = 0;
   localparam int STAT_MATH = 1;
   localparam int STAT_THR = 2;
   localparam int STAT_PEND = 3;
   localparam int STAT_BUSY = 4;
   localparam int STAT_OFF = 5;
   localparam int RES_BITS = 12;
   localparam logic [12:0] ACQ_MAX = 13'h1fff;
   localparam logic [5:0] CLKDIV_RST = 6'h00;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   typedef enum logic [2:0] {ACS_IDLE, ACS_DELAY, ACS_ACQ, ACS_CONV, ACS_DONE} acs_state_e;
endpackage : acs_pkg

// ### hw/acs_clock_divider.sv
`timescale 1ns/100ps
module acs_clock_divider
   import acs_pkg::*;
#(
   parameter int DIV_BITS = 6
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control
   input wire logic [DIV_BITS-1:0] divCode,
   input wire logic useRc,
   input wire logic rcTick,
   // Converter clock enable
   output logic convTick
);
   logic [DIV_BITS:0] count;
   logic [DIV_BITS:0] terminal;

   // Count runs 0 to 2*code+1, one extra bit so code 63 still reaches 127
   assign terminal = {divCode, 1'b1};

   always_ff @(posedge clk) begin
      if (reset || useRc) begin
         count <= '0;
      end else if (count == terminal) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   // One pulse per full divided period
   always_comb begin
      convTick = useRc ? rcTick : (count == terminal);
   end
endmodule : acs_clock_divider

// ### hw/acs_sequencer.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int INSTR_CYCLES = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clocking and power state
   input wire logic rcTick,
   input wire logic sleeping,
   // Trigger sources
   input wire logic extTrigger,
   input wire logic [7:0] autoSources,
   // Analog comparator and sample control
   input wire logic compareHigh,
   output logic [RES_BITS-1:0] dacCode,
   output logic sampling,
   output logic converterPowered,
   // Wake request and done status
   output logic wake,
   output logic conversionDone
);
   logic [15:0] ctrl;
   logic [5:0] clockDividerReg;
   logic [15:0] resultPair;
   logic [15:0] prevResult;
   logic [31:0] accumulatorReg;
   logic [12:0] acquisitionTimeReg;
   logic [12:0] precharge;
   logic [15:0] threshold;
   logic [2:0] autoTriggerSelect;
   logic doneFlag, mathFlag, thresholdFlag, pending, convOff, secondSample, trigLast;
   logic [12:0] acqCount;
   logic [3:0] bitIdx;
   logic [3:0] delayCount;
   logic [RES_BITS-1:0] sar;
   logic [RES_BITS-1:0] newResult;
   acs_state_e state;
   logic convTick, wr, rd, startReq, autoEdge, finish, useRc, canRun, evalErr, errHit;
   logic [15:0] errVal;

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~pwrite;
   assign pready = 1'b1;
   assign useRc = ctrl[CTRL_CLKSEL];
   assign newResult = {sar[RES_BITS-1:1], compareHigh};
   assign finish = state == ACS_CONV && convTick && bitIdx == 4'd0;
   assign autoEdge = autoSources[autoTriggerSelect] & ~trigLast;
   // Sleep without RC clock holds off any new start; a running conversion carries on
   assign canRun = ~sleeping | useRc;
   assign startReq = ctrl[CTRL_ON] & ctrl[CTRL_START] & canRun & ~convOff;
   assign dacCode = sar;
   assign sampling = state == ACS_ACQ;
   assign converterPowered = ctrl[CTRL_ON] & ~convOff;
   assign conversionDone = doneFlag;
   assign wake = sleeping & doneFlag & ctrl[CTRL_IRQEN];
   assign evalErr = finish & (~ctrl[CTRL_DSEN] | secondSample);
   assign errVal = {4'h0, newResult} - prevResult;
   assign errHit = $signed(errVal) > $signed(threshold);

   acs_clock_divider #(
      .DIV_BITS(6)
   ) u_div (
      .clk(clk),
      .reset(reset),
      .divCode(clockDividerReg),
      .useRc(useRc),
      .rcTick(rcTick),
      .convTick(convTick)
   );

   // Control register; hardware start set and clear beat software clear
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl <= CTRL_RST;
      end else begin
         if (wr && paddr == ADDR_CTRL) begin
            ctrl <= pwdata[15:0];
         end
         if ((extTrigger && ctrl[CTRL_ON]) || autoEdge || (pending && canRun)) begin
            ctrl[CTRL_START] <= 1'b1;
         end
         if (finish && !ctrl[CTRL_CONTINUOUS_BIT]) begin
            ctrl[CTRL_START] <= 1'b0;
         end
      end
   end

   // Trigger held while sleep blocks the converter
   always_ff @(posedge clk) begin
      if (reset) begin
         pending <= 1'b0;
         trigLast <= 1'b0;
      end else begin
         trigLast <= autoSources[autoTriggerSelect];
         if (extTrigger && sleeping && !useRc) begin
            pending <= 1'b1;
         end else if (!sleeping) begin
            pending <= 1'b0;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clk) begin
      if (reset) begin
         clockDividerReg <= CLKDIV_RST;
         acquisitionTimeReg <= '0;
         precharge <= '0;
         threshold <= '0;
         autoTriggerSelect <= '0;
      end else if (wr) begin
         case (paddr)
            ADDR_CLKDIV: clockDividerReg <= pwdata[5:0];
            ADDR_ACQ: acquisitionTimeReg <= pwdata[12:0];
            ADDR_PRE: precharge <= pwdata[12:0];
            ADDR_THRESH: threshold <= pwdata[15:0];
            ADDR_TRIG: autoTriggerSelect <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // Conversion sequence; acquisition and bit steps move on converter ticks, the RC start delay on clocks
   always_ff @(posedge clk) begin
      if (reset || !ctrl[CTRL_ON]) begin
         state <= ACS_IDLE;
         sar <= '0;
         bitIdx <= '0;
         acqCount <= '0;
         delayCount <= '0;
      end else begin
         unique case (state)
            ACS_IDLE: begin
               if (startReq) begin
                  state <= useRc ? ACS_DELAY : ACS_ACQ;
                  delayCount <= 4'(INSTR_CYCLES);
                  // Zero acquisition with precharge means longest; else skip timing
                  acqCount <= (acquisitionTimeReg == 13'h0000 && precharge != 13'h0000)
                     ? ACQ_MAX : acquisitionTimeReg;
               end
            end
            ACS_DELAY: begin
               // Extra instruction so the core can reach sleep first
               if (delayCount == 4'd1) begin
                  state <= ACS_ACQ;
               end
               delayCount <= delayCount - 4'd1;
            end
            ACS_ACQ: begin
               if (acqCount == 13'h0000) begin
                  state <= ACS_CONV;
                  sar <= 12'h800;
                  bitIdx <= 4'd11;
               end else if (convTick) begin
                  acqCount <= acqCount - 13'h0001;
               end
            end
            ACS_CONV: begin
               if (convTick) begin
                  // Keep trial bit if input above, then try the next one
                  sar[bitIdx] <= compareHigh;
                  if (bitIdx != 4'd0) begin
                     sar[bitIdx - 4'd1] <= 1'b1;
                     bitIdx <= bitIdx - 4'd1;
                  end else begin
                     state <= ACS_DONE;
                  end
               end
            end
            ACS_DONE: state <= ACS_IDLE;
         endcase
      end
   end

   // Result, previous value and accumulator
   always_ff @(posedge clk) begin
      if (reset) begin
         resultPair <= '0;
         prevResult <= '0;
         accumulatorReg <= '0;
         secondSample <= 1'b0;
      end else begin
         if (wr && paddr == ADDR_RESULT) begin
            resultPair <= pwdata[15:0];
         end
         if (wr && paddr == ADDR_ACC) begin
            accumulatorReg <= pwdata;
         end
         if (finish) begin
            if (ctrl[CTRL_PSIS]) begin
               prevResult <= resultPair;
            end
            resultPair <= {4'h0, newResult};
            accumulatorReg <= accumulatorReg + {20'h00000, newResult};
            secondSample <= ctrl[CTRL_DSEN] & ~secondSample;
         end
      end
   end

   // Sticky flags; hardware set beats software clear
   always_ff @(posedge clk) begin
      if (reset) begin
         doneFlag <= 1'b0;
         mathFlag <= 1'b0;
         thresholdFlag <= 1'b0;
         convOff <= 1'b0;
      end else begin
         if (wr && paddr == ADDR_STATUS) begin
            doneFlag <= doneFlag & ~pwdata[STAT_DONE];
            mathFlag <= mathFlag & ~pwdata[STAT_MATH];
            thresholdFlag <= thresholdFlag & ~pwdata[STAT_THR];
         end
         if (finish) begin
            doneFlag <= 1'b1;
            mathFlag <= 1'b1;
         end
         // Threshold judged on the finishing cycle, ready with the done flag
         if (evalErr && errHit) begin
            thresholdFlag <= 1'b1;
         end
         if (finish && sleeping && !ctrl[CTRL_IRQEN]) begin
            convOff <= 1'b1;
         end else if (!sleeping) begin
            convOff <= 1'b0;
         end
      end
   end

   // Read mux; left justify per format bit
   always_comb begin
      prdata = 32'h00000000;
      if (rd) begin
         case (paddr)
            ADDR_CTRL: prdata = {16'h0000, ctrl};
            ADDR_CLKDIV: prdata = {26'h0, clockDividerReg};
            ADDR_RESULT: prdata = ctrl[CTRL_FORMAT] ? {16'h0000, resultPair}
               : {16'h0000, resultPair[11:0], 4'h0};
            ADDR_PREV: prdata = {16'h0000, prevResult};
            ADDR_ACC: prdata = accumulatorReg;
            ADDR_ACQ: prdata = {19'h0, acquisitionTimeReg};
            ADDR_PRE: prdata = {19'h0, precharge};
            ADDR_THRESH: prdata = {16'h0000, threshold};
            ADDR_STATUS: prdata = {26'h0, convOff, state != ACS_IDLE, pending,
               thresholdFlag, mathFlag, doneFlag};
            ADDR_TRIG: prdata = {29'h0, autoTriggerSelect};
            default: prdata = 32'h00000000;
         endcase
      end
   end

   assign pslverr = psel & penable & (paddr > ADDR_TRIG | paddr[1:0] != 2'b00);
endmodule : acs_sequencer

// ### verification/acs_sequencer_props.sv
`timescale 1ns/100ps
module acs_sequencer_props
   import acs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Converter state
   input wire logic sleeping,
   input wire logic sampling,
   input wire logic converterPowered,
   input wire logic wake,
   input wire logic conversionDone
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic access;
   logic doneClear;
   logic badAddr;
   assign access = psel && penable;
   assign doneClear = access && pwrite && paddr == ADDR_STATUS && pwdata[STAT_DONE];
   assign badAddr = paddr > ADDR_TRIG || paddr[1:0] != 2'h0;
   ready_always_a: assert property (access |-> pready)
      else $error("access phase without ready");
   refuse_bad_a: assert property (access && badAddr |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   accept_good_a: assert property (access && !badAddr |-> !pslverr)
      else $error("mapped access refused");
   reset_idle_a: assert property ($fell(reset) |-> !conversionDone && !sampling && !wake)
      else $error("not idle after reset");
   done_sticky_a: assert property (conversionDone && !doneClear |=> conversionDone)
      else $error("done flag dropped without software clear");
   wake_cause_a: assert property (wake |-> sleeping && conversionDone)
      else $error("wake without sleeping completion");
   done_cause_a: assert property ($rose(conversionDone) |-> $past(converterPowered))
      else $error("done set with converter unpowered");
   sample_power_a: assert property (sampling |-> converterPowered)
      else $error("sampling while converter off");
endmodule : acs_sequencer_props
bind acs_sequencer acs_sequencer_props PROPS (.clk, .reset, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .sleeping, .sampling, .converterPowered, .wake,
   .conversionDone);

// ### verification/acs_analog_model.sv
`timescale 1ns/100ps
module acs_analog_model
   import acs_pkg::*;
#(
   parameter int RC_DIV = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Analog level and trial code
   input wire logic [RES_BITS-1:0] level,
   input wire logic [RES_BITS-1:0] dacCode,
   // Comparator and RC oscillator
   output logic compareHigh,
   output logic rcTick
);
   int rcCount;
   // Half-LSB offset so the search lands exactly on the level
   assign compareHigh = {level, 1'b1} > {dacCode, 1'b0};
   // RC runs free, unrelated to the divider
   always_ff @(posedge clk) begin
      if (reset || rcCount == RC_DIV - 1) begin
         rcCount <= 0;
      end else begin
         rcCount <= rcCount + 1;
      end
   end
   assign rcTick = rcCount == RC_DIV - 1;
endmodule : acs_analog_model

// ### verification/test_adc_conversion_sequencer.sv
`timescale 1ns/100ps
module test_adc_conversion_sequencer
   import acs_pkg::*;
;
   localparam logic [31:0] ON = 32'h1 << CTRL_ON;
   localparam logic [31:0] RJ = 32'h1 << CTRL_FORMAT;
   localparam logic [31:0] RC = 32'h1 << CTRL_CLKSEL;
   localparam logic [31:0] IE = 32'h1 << CTRL_IRQEN;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, sleeping = 0, extTrigger = 0;
   logic [7:0] paddr = 8'h00, autoSources = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [11:0] level = 12'h000, dacCode;
   logic pready, pslverr, err, compareHigh, rcTick, sampling, converterPowered, wake;
   logic conversionDone;
   int failures = 0, n_checks = 0;
   always #25 clk = ~clk;
   acs_sequencer DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rcTick(rcTick), .sleeping(sleeping), .extTrigger(extTrigger),
      .autoSources(autoSources), .compareHigh(compareHigh), .dacCode(dacCode),
      .sampling(sampling), .converterPowered(converterPowered), .wake(wake),
      .conversionDone(conversionDone));
   acs_analog_model MODEL (.clk(clk), .reset(reset), .level(level), .dacCode(dacCode),
      .compareHigh(compareHigh), .rcTick(rcTick));
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Wait ends on the first edge that sees pready high
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_done();
      int n;
      n = 0;
      while (conversionDone !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      chk(32'(conversionDone), 32'h1);
   endtask : wait_done
   task automatic conv(input logic [31:0] ctrl, input logic [11:0] lv);
      level <= lv;
      apb(1'b1, ADDR_CTRL, ctrl);
      repeat (4) @(posedge clk);
      apb(1'b1, ADDR_CTRL, ctrl | 32'h1);
      wait_done();
   endtask : conv
   task automatic pulse();
      @(posedge clk);
      extTrigger <= 1'b1;
      @(posedge clk);
      extTrigger <= 1'b0;
   endtask : pulse
   task automatic t_reset();
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd & 32'h1f, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
      $display("reset test done");
   endtask : t_reset
   task automatic t_basic();
      conv(ON | RJ | (32'h1 << CTRL_PSIS), 12'h5a3);
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk(rd, 32'h5a3);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd & 32'h3, 32'h3);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd & 32'h1, 32'h0);
      apb(1'b1, ADDR_STATUS, 32'h7);
      // Clear lands at the edge the task returns on
      @(posedge clk);
      chk(32'(conversionDone), 32'h0);
      conv(ON | RJ | (32'h1 << CTRL_PSIS), 12'h7c1);
      apb(1'b0, ADDR_PREV, 32'h0);
      chk(rd, 32'h5a3);
      apb(1'b0, ADDR_ACC, 32'h0);
      chk(rd, 32'hd64);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rd[STAT_THR]), 32'h1);
      apb(1'b1, ADDR_CTRL, ON);
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk(rd, 32'h7c10);
      apb(1'b1, ADDR_RESULT, 32'h123);
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk(rd, 32'h1230);
      apb(1'b1, ADDR_STATUS, 32'h7);
      $display("basic test done");
   endtask : t_basic
   task automatic t_triggers();
      level <= 12'h0ff;
      apb(1'b1, ADDR_CTRL, ON | RJ);
      pulse();
      wait_done();
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk(rd, 32'h0ff);
      apb(1'b1, ADDR_STATUS, 32'h7);
      apb(1'b1, ADDR_TRIG, 32'h2);
      level <= 12'h800;
      autoSources <= 8'h04;
      wait_done();
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk(rd, 32'h800);
      autoSources <= 8'h00;
      apb(1'b1, ADDR_STATUS, 32'h7);
      $display("trigger test done");
   endtask : t_triggers
   task automatic t_sleep();
      apb(1'b1, ADDR_CTRL, ON | RJ | RC | IE);
      sleeping <= 1'b1;
      pulse();
      wait_done();
      chk(32'(wake), 32'h1);
      sleeping <= 1'b0;
      apb(1'b1, ADDR_STATUS, 32'h7);
      apb(1'b1, ADDR_CTRL, ON | RJ | RC);
      sleeping <= 1'b1;
      pulse();
      wait_done();
      chk(32'(converterPowered), 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd & ON, ON);
      sleeping <= 1'b0;
      apb(1'b1, ADDR_STATUS, 32'h7);
      apb(1'b1, ADDR_CTRL, ON | RJ);
      sleeping <= 1'b1;
      pulse();
      repeat (300) @(posedge clk);
      chk(32'(conversionDone), 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rd[STAT_PEND]), 32'h1);
      sleeping <= 1'b0;
      wait_done();
      apb(1'b1, ADDR_STATUS, 32'h7);
      $display("sleep test done");
   endtask : t_sleep
   task automatic t_continuous_bit();
      conv(ON | RJ | (32'h1 << CTRL_CONTINUOUS_BIT), 12'h321);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd & 32'h1, 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_STATUS, 32'h7);
      $display("continuous test done");
   endtask : t_continuous_bit
   task automatic t_double();
      // Previous result still holds 0x5a3, so the error is positive
      conv(ON | RJ | (32'h1 << CTRL_DSEN), 12'h7ff);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rd[STAT_THR]), 32'h0);
      apb(1'b1, ADDR_STATUS, 32'h7);
      conv(ON | RJ | (32'h1 << CTRL_DSEN), 12'h7ff);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rd[STAT_THR]), 32'h1);
      apb(1'b1, ADDR_STATUS, 32'h7);
      $display("double sample test done");
   endtask : t_double
   task automatic tick_gap(input logic [5:0] code, input int exp);
      logic [11:0] last;
      int n;
      level <= 12'h000;
      apb(1'b1, ADDR_CLKDIV, {26'h0, code});
      apb(1'b1, ADDR_CTRL, ON | RJ);
      apb(1'b1, ADDR_CTRL, ON | RJ | 32'h1);
      // Third trial change is the first full converter period
      for (int k = 0; k < 3; k++) begin
         last = dacCode;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (dacCode == last && n < 300);
      end
      chk(32'(n), 32'(exp));
      wait_done();
      apb(1'b1, ADDR_STATUS, 32'h7);
      apb(1'b1, ADDR_CTRL, 32'h0);
   endtask : tick_gap
   task automatic t_abort();
      level <= 12'h0aa;
      apb(1'b1, ADDR_CTRL, ON | RJ);
      apb(1'b1, ADDR_CTRL, ON | RJ | 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rd[STAT_BUSY]), 32'h1);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd & 32'h3f, 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      chk(32'(dacCode), 32'h0);
      $display("abort test done");
   endtask : t_abort
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_basic();
      t_triggers();
      t_sleep();
      t_double();
      t_continuous_bit();
      tick_gap(6'h03, 8);
      tick_gap(6'h3f, 128);
      $display("divider test done");
      t_abort();
      complete_run();
   end
   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      complete_run();
   end
endmodule : test_adc_conversion_sequencer
